// file: hdl/srw_top.sv
/*
 Supervisor: stretched reset, watchdog, power-fail flag.
 Assumes pin inputs are asynchronous; supply_low comes from an analog
 comparator, kick_float from a floating-pin detector.
*/
`timescale 1ns/100ps
`include "srw_consts.svh"
module srw_top #(
   parameter int          RST_CYCLES = `SRW_RST_CYCLES,
   parameter int          WD_CYCLES  = `SRW_WD_CYCLES,
   parameter bit          DUAL_OUT   = 1'b0
) (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_b_i,
   // Monitored pins
   input  wire srw_pkg::srw_pins_s pins_i,
   // Outputs
   output logic                   reset_n_o,
   output logic                   reset_o,
   output logic                   power_fail_flag_n_o,
   output logic                   watchdog_expired_n_o
);
   import srw_pkg::*;

   // ---------------------------------------------
   // Input synchronisation
   // ---------------------------------------------
   logic [4:0] raw;
   logic [4:0] sy;
   assign raw = {pins_i.supply_low, pins_i.manual_reset_n, pins_i.power_fail_sense,
                 pins_i.watchdog_kick, pins_i.watchdog_kick_float};
   srw_sync #(.W(5)) u_sync (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .d_i     (raw),
      .q_o     (sy)
   );
   wire supply_low = sy[4];
   wire mr_low     = ~sy[3];
   wire pf_below   = sy[2];
   wire kick       = sy[1];
   wire kick_float = sy[0];

   // ---------------------------------------------
   // Count limits
   // ---------------------------------------------
   // A window of N cycles ends on count N-1
   localparam logic [`SRW_CNT_W-1:0] RST_LAST = `SRW_CNT_W'(RST_CYCLES - 1);
   localparam logic [`SRW_CNT_W-1:0] WD_LAST  = `SRW_CNT_W'(WD_CYCLES - 1);

   // ---------------------------------------------
   // Variant selection
   // ---------------------------------------------
   // Dual-output build drops the watchdog; reset and power-fail flag remain
   wire wd_fitted = ~DUAL_OUT;

   // ---------------------------------------------
   // Reset stretcher state
   // ---------------------------------------------
   srw_rst_e              st_q;
   srw_rst_e              st_d;
   logic [`SRW_CNT_W-1:0] rcnt_q;
   logic [`SRW_CNT_W-1:0] rcnt_d;
   // Watchdog expiry deliberately not an input here
   wire hold_src = supply_low | mr_low;
   wire rdone    = (rcnt_q >= RST_LAST);

   always_comb begin
      case (st_q)
         ST_HOLD: begin
            if (hold_src) begin
               st_d = ST_HOLD;
            end else begin
               st_d = ST_STRETCH;
            end
         end
         ST_STRETCH: begin
            if (hold_src) begin
               st_d = ST_HOLD;
            end else if (rdone) begin
               st_d = ST_RUN;
            end else begin
               st_d = ST_STRETCH;
            end
         end
         ST_RUN: begin
            if (hold_src) begin
               st_d = ST_HOLD;
            end else begin
               st_d = ST_RUN;
            end
         end
         default: begin
            st_d = ST_HOLD;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         st_q <= ST_HOLD;
      end else begin
         st_q <= st_d;
      end
   end

   // ---------------------------------------------
   // Stretch counter
   // ---------------------------------------------
   // Cleared outside STRETCH, so a retrigger restarts the full window
   wire cnt_run = (st_q == ST_STRETCH) & ~hold_src;
   assign rcnt_d = cnt_run ? rcnt_q + 1'b1 : '0;

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         rcnt_q <= '0;
      end else begin
         rcnt_q <= rcnt_d;
      end
   end

   // ---------------------------------------------
   // Reset outputs
   // ---------------------------------------------
   // Held low in HOLD and STRETCH: every trigger yields at least the full stretch
   wire rst_active = (st_q != ST_RUN);
   wire rst_n_d    = ~rst_active;
   wire rst_hi_d   = DUAL_OUT & rst_active;

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         reset_n_o <= 1'b0;
      end else begin
         reset_n_o <= rst_n_d;
      end
   end

   // In the dual build the complement holds in reset too, so the two pins never agree
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         reset_o <= DUAL_OUT;
      end else begin
         reset_o <= rst_hi_d;
      end
   end

   // ---------------------------------------------
   // Power-fail flag
   // ---------------------------------------------
   wire pf_flag_d = ~pf_below;

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         power_fail_flag_n_o <= 1'b1;
      end else begin
         power_fail_flag_n_o <= pf_flag_d;
      end
   end

   // ---------------------------------------------
   // Kick edge detector
   // ---------------------------------------------
   logic kick_q;
   // Both edges count; reset level matches the synchroniser's, so no false edge
   wire kick_edge = (kick != kick_q);

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         kick_q <= 1'b0;
      end else begin
         kick_q <= kick;
      end
   end

   // ---------------------------------------------
   // Watchdog counter
   // ---------------------------------------------
   logic [`SRW_CNT_W-1:0] wcnt_q;
   logic [`SRW_CNT_W-1:0] wcnt_d;
   // Stale kick level while floating could fake an edge; float clears anyway
   wire wd_off   = ~wd_fitted | kick_float;
   wire wd_clear = wd_off | rst_active | kick_edge;
   wire wd_hit   = (wcnt_q >= WD_LAST);
   // Parks at the limit instead of wrapping back to zero
   assign wcnt_d = wd_clear ? '0 : (wd_hit ? wcnt_q : wcnt_q + 1'b1);

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         wcnt_q <= '0;
      end else begin
         wcnt_q <= wcnt_d;
      end
   end

   // ---------------------------------------------
   // Expiry flag
   // ---------------------------------------------
   logic exp_q;
   wire  exp_d = wd_clear ? 1'b0 : (exp_q | wd_hit);

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         exp_q <= 1'b0;
      end else begin
         exp_q <= exp_d;
      end
   end

   // ---------------------------------------------
   // Expiry output
   // ---------------------------------------------
   // Supply-low forcing bypasses the stretcher so release has no delay
   wire wdo_d = ~wd_fitted | ~(exp_q | supply_low);

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         watchdog_expired_n_o <= DUAL_OUT;
      end else begin
         watchdog_expired_n_o <= wdo_d;
      end
   end
endmodule // srw_top

// file: inc/srw_consts.svh
/*
 Timing constants for the supervisor reset and watchdog block.
 Assumes a 125 MHz system clock; included by the top-level design file only.
*/
`ifndef SRW_CONSTS_SVH
`define SRW_CONSTS_SVH
`define SRW_CLK_HZ        125000000
`define SRW_RST_STRETCH_MS 200
`define SRW_WD_TIMEOUT_MS  1600
`define SRW_RST_CYCLES    ((`SRW_CLK_HZ / 1000) * `SRW_RST_STRETCH_MS)
`define SRW_WD_CYCLES     ((`SRW_CLK_HZ / 1000) * `SRW_WD_TIMEOUT_MS)
`define SRW_CNT_W         32
`endif

// file: inc/srw_pkg.sv
/*
 Types for the supervisor reset and watchdog block.
 Assumes nothing beyond the constants header.
*/
package srw_pkg;
   // ---------------------------------------------
   // Pin-level inputs grouped
   // ---------------------------------------------
   typedef struct packed {
      logic supply_low;
      logic manual_reset_n;
      logic power_fail_sense;
      logic watchdog_kick;
      logic watchdog_kick_float;
   } srw_pins_s;
   typedef enum logic [1:0] {ST_HOLD, ST_STRETCH, ST_RUN} srw_rst_e;
endpackage

// file: hdl/srw_sync.sv
/*
 Two-flop synchroniser, one per bit through a generate loop.
 Assumes asynchronous inputs and one clock.
*/
`timescale 1ns/100ps
module srw_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   // Data
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic meta_q;
         logic sync_q;
         always_ff @(posedge clk_i) begin
            if (!rst_b_i) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else begin
               meta_q <= d_i[g];
               sync_q <= meta_q;
            end
         end
         assign q_o[g] = sync_q;
      end
   endgenerate
endmodule // srw_sync

// file: test/srw_top_sva.sv
/* Checker on the srw_top ports.
   Assumes it is bound into every srw_top. */
`timescale 1ns/100ps
module srw_top_sva #(
   parameter int RST_CYCLES = 20,
   parameter int WD_CYCLES  = 50,
   parameter bit DUAL_OUT   = 1'b0
) (
   input wire logic               clk_i,
   input wire logic               rst_b_i,
   input wire srw_pkg::srw_pins_s pins_i,
   input wire logic               reset_n_o,
   input wire logic               reset_o,
   input wire logic               power_fail_flag_n_o,
   input wire logic               watchdog_expired_n_o
);
   logic [2:0] up_q;
   logic       kick_q;
   int         quiet_q, kq_q;
   // Design lags these pin-level counters by the synchroniser, hence the slack
   always_ff @(posedge clk_i) begin
      up_q <= {up_q[1:0], rst_b_i};
      kick_q <= pins_i.watchdog_kick;
      quiet_q <= (!rst_b_i || !pins_i.manual_reset_n || pins_i.supply_low) ? 0 : quiet_q + 1;
      kq_q <= (!rst_b_i || !reset_n_o || pins_i.watchdog_kick_float
         || pins_i.watchdog_kick != kick_q) ? 0 : kq_q + 1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   AST_PF: assert property (&up_q |->
      power_fail_flag_n_o == !$past(pins_i.power_fail_sense, 3)) else $error("pf");
   AST_MR: assert property ($fell(pins_i.manual_reset_n) |-> ##4 !reset_n_o)
      else $error("mr");
   AST_HOLD: assert property (pins_i.supply_low [*4] |=> !reset_n_o) else $error("hold");
   AST_STRETCH: assert property ($rose(reset_n_o) |->
      quiet_q >= RST_CYCLES && quiet_q <= RST_CYCLES + 8) else $error("stretch");
   AST_WD_TO: assert property ($fell(watchdog_expired_n_o) && !$past(pins_i.supply_low, 3)
      |-> kq_q >= WD_CYCLES && kq_q <= WD_CYCLES + 8) else $error("wd");
   AST_WD_LOW: assert property (pins_i.supply_low [*3] |=> !watchdog_expired_n_o || DUAL_OUT)
      else $error("lowline");
   AST_CAUSE: assert property ($fell(reset_n_o) |->
      !$past(pins_i.manual_reset_n, 4) || $past(pins_i.supply_low, 4)) else $error("cause");
   AST_DUAL: assert property (&up_q |-> reset_o == (DUAL_OUT && !reset_n_o) &&
      (watchdog_expired_n_o || !DUAL_OUT)) else $error("dual");
endmodule // srw_top_sva
bind srw_top srw_top_sva #(.RST_CYCLES(RST_CYCLES), .WD_CYCLES(WD_CYCLES), .DUAL_OUT(DUAL_OUT))
   i_sva (.clk_i(clk_i), .rst_b_i(rst_b_i), .pins_i(pins_i), .reset_n_o(reset_n_o),
   .reset_o(reset_o), .power_fail_flag_n_o(power_fail_flag_n_o),
   .watchdog_expired_n_o(watchdog_expired_n_o));

// file: test/srw_cpu_model.sv
/* Processor model that kicks the watchdog.
   Assumes reset_n_i is the supervisor reset. */
`timescale 1ns/100ps
module srw_cpu_model (
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   input  wire logic run_i,
   input  wire logic float_i,
   output logic      kick_o
);
   int   n = 0;
   logic lvl_q = 1'b0;
   always @(posedge clk_i) begin
      n <= (n + 1) % 8;
      if (reset_n_i && run_i && !float_i && n == 0) lvl_q <= ~lvl_q;
   end
   // Released pin shows the inverse of its last level, then holds still
   assign kick_o = float_i ? ~lvl_q : lvl_q;
endmodule // srw_cpu_model

// file: test/test_srw_top.sv
/* Bench for srw_top with a processor model and a power-fail reference.
   Assumes the checker binds itself to srw_top. */
`timescale 1ns/100ps
module test_srw_top;
   import srw_pkg::*;
   localparam int RST = 20;
   localparam int WD  = 50;
   logic      clk_i = 0, rst_b_i = 0, sup = 0, mr_n = 1, pfs = 0, run = 0, flt = 0;
   logic      rn, ro, pfn, wdn, kick;
   logic      rn2, ro2, pfn2, wdn2, pf_exp;
   int        num_errors = 0, checks = 0, seed = 32'hdd62;
   bit        q[$];
   srw_pins_s pins;
   assign pins = {sup, mr_n, pfs, kick, flt};
   srw_top #(.RST_CYCLES(RST), .WD_CYCLES(WD)) i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .pins_i(pins), .reset_n_o(rn), .reset_o(ro), .power_fail_flag_n_o(pfn),
      .watchdog_expired_n_o(wdn));
   srw_cpu_model i_cpu (.clk_i(clk_i), .reset_n_i(rn), .run_i(run), .float_i(flt),
      .kick_o(kick));
   srw_top #(.RST_CYCLES(RST), .WD_CYCLES(WD), .DUAL_OUT(1'b1)) i_dut_dual (.clk_i(clk_i),
      .rst_b_i(rst_b_i), .pins_i(pins), .reset_n_o(rn2), .reset_o(ro2),
      .power_fail_flag_n_o(pfn2), .watchdog_expired_n_o(wdn2));
   task automatic chk(input string w, input logic s, input logic e);
      checks++;
      if (s !== e) begin
         num_errors++;
         $display("unexpected %s exp %b seen %b", w, e, s);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic step(input int c);
      repeat (c) @(posedge clk_i);
   endtask
   initial forever #4 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      pfs <= 1'($random(seed));
      q.push_back(pfs);
      if (!rst_b_i) q.delete();
      else begin
         chk("dual rst", ro2, !rn2);
         chk("dual wd", wdn2, 1'b1);
         if (q.size() > 3) begin
            pf_exp = !q.pop_front();
            chk("pf", pfn, pf_exp);
            chk("pf dual", pfn2, pf_exp);
         end
      end
   end
   initial begin
      step(2);
      rst_b_i <= 1'b1;
      step(RST + 12);
      chk("rst up", rn, 1'b1);
      chk("rst hi", ro, 1'b0);
      run <= 1'b1;
      step(3 * WD);
      chk("kicked", wdn, 1'b1);
      run <= 1'b0;
      step(WD + 24);
      chk("wd out", wdn, 1'b0);
      chk("no wd rst", rn, 1'b1);
      flt <= 1'b1;
      step(3 * WD);
      chk("float", wdn, 1'b1);
      flt <= 1'b0;
      run <= 1'b1;
      mr_n <= 1'b0;
      step(6);
      chk("mr", rn, 1'b0);
      mr_n <= 1'b1;
      step(RST);
      chk("stretch", rn, 1'b0);
      sup <= 1'b1;
      step(6);
      chk("low rst", rn, 1'b0);
      chk("low wd", wdn, 1'b0);
      sup <= 1'b0;
      step(5);
      chk("wd back", wdn, 1'b1);
      chk("rst kept", rn, 1'b0);
      rst_b_i <= 1'b0;
      step(2);
      chk("in reset", rn, 1'b0);
      rst_b_i <= 1'b1;
      step(RST + 12);
      chk("rst again", rn, 1'b1);
      chk("wd again", wdn, 1'b1);
      tally_and_finish;
   end
endmodule // test_srw_top
